/* File: rtl/bmcc_conv_ctrl.sv */
// Conversion sequencer, serial link, alert and daisy-chain relays
//
// Function
// - One start runs all twelve channels: six cells, six auxiliary.
// - A rising chip-select edge may also start the sequence.
// - Each channel result goes to its own result word.
// - Each channel slot lasts at least 1 us.
// - An acquisition setting lengthens each acquisition.
// - Averaging setting repeats each measurement two, four or eight times.
// - Only the averaged value is stored.
// - After reset: single conversion, 1 us default slot.
// - Results are read and words written over the four-wire serial link.
// - Alert when a result is above upper or below lower threshold.
// - Alert mode and thresholds come from stored settings.
// - Six independent on/off cell balance outputs.
// - Data from devices above is forwarded down the chain.
// - Serial control is relayed up the chain.
// - Convert start acts on its falling edge.
// - Data shifts out on rising serial clock; 32 clocks per word.
// - Top cell first, then lower cells, then auxiliary channels.
`timescale 1ns/100ps
`default_nettype none
module bmcc_conv_ctrl (
   input  wire logic               ref_clk_i,
   input  wire logic               arst_n_i,
   input  wire logic               convert_start_n_i,
   output logic                    convert_start_relay_up_o,
   input  wire logic               spi_sclk_i,
   input  wire logic               spi_cs_n_i,
   input  wire logic               spi_sdi_i,
   output logic                    spi_sdo_o,
   output logic                    sclk_hi_o,
   output logic                    cs_hi_n_o,
   output logic                    sdo_hi_o,
   input  wire logic               sdi_hi_i,
   output logic                    sdo_lo_o,
   input  wire logic               alert_hi_i,
   output logic                    alert_o,
   output logic                    alert_lo_o,
   input  wire logic               chain_pass_i,
   input  wire logic               cs_conv_en_i,
   input  wire logic [1:0]         avg_sel_i,
   input  wire logic [1:0]         acq_sel_i,
   input  wire bmcc_pkg::bmcc_thr_s thr_i,
   input  wire logic [5:0]         cb_en_i,
   output logic      [5:0]         cell_balance_out_o,
   output bmcc_pkg::bmcc_adc_req_s adc_req_o,
   input  wire bmcc_pkg::bmcc_adc_rsp_s adc_rsp_i,
   output logic                    busy_o,
   output logic      [31:0]        rx_word_o,
   output logic                    rx_valid_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [bmcc_pkg::N_SY-1:0][2:0]       sy;
      logic [bmcc_pkg::N_SY-1:0]            lvl;
      bmcc_pkg::bmcc_state_e                st;
      logic [3:0]                           chan;
      logic [2:0]                           rep;
      logic [9:0]                           cnt;
      logic                                 got;
      logic [bmcc_pkg::ACC_W-1:0]           acc;
      logic [1:0]                           avg;
      logic [1:0]                           acq;
      logic                                 adc_start;
      logic                                 wr_en;
      logic [3:0]                           wr_addr;
      logic [bmcc_pkg::RES_W-1:0]           wr_data;
      logic [bmcc_pkg::N_CHAN-1:0]          alert_vec;
      logic                                 alert;
      logic [5:0]                           cb;
      logic [bmcc_pkg::FRAME_BITS-1:0]      sh_out;
      logic [bmcc_pkg::FRAME_BITS-1:0]      sh_in;
      logic [5:0]                           bitcnt;
      logic [3:0]                           rd_ptr;
      logic                                 sdo;
      logic [bmcc_pkg::FRAME_BITS-1:0]      rx_word;
      logic                                 rx_valid;
   } bmcc_ctl_s;

   bmcc_ctl_s q;
   bmcc_ctl_s d;

   logic [bmcc_pkg::N_SY-1:0]  pins;
   logic [bmcc_pkg::N_SY-1:0]  chg;
   logic [bmcc_pkg::N_SY-1:0]  rise;
   logic [bmcc_pkg::N_SY-1:0]  fall;
   logic                       start_req;
   logic [bmcc_pkg::RES_W-1:0] rdata;

   if (bmcc_pkg::N_CHAN != 12 || bmcc_pkg::ACC_W != bmcc_pkg::RES_W + 3) begin : g_chk
      $error("channel count or accumulator width not served");
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [9:0] acq_len(input logic [1:0] s);
      return 10'(bmcc_pkg::ACQ_BASE_CYC) + 10'(s) * 10'(bmcc_pkg::ACQ_STEP_CYC);
   endfunction

   function automatic logic [9:0] slot_len(input logic [1:0] s);
      return 10'(bmcc_pkg::CHAN_CYC) + 10'(s) * 10'(bmcc_pkg::ACQ_STEP_CYC);
   endfunction

   function automatic logic out_of_range(input logic [3:0] ch,
                                         input logic [11:0] v,
                                         input bmcc_pkg::bmcc_thr_s t);
      if (ch < 4'(bmcc_pkg::N_CELL)) begin
         return t.mode[0] && (v > t.cell_hi || v < t.cell_lo);
      end
      return t.mode[1] && (v > t.aux_hi || v < t.aux_lo);
   endfunction

   // ----------------------------------------------------------------
   // Pin sampling: a change counts once second and third stage agree
   // ----------------------------------------------------------------
   assign pins = {sdi_hi_i, alert_hi_i, convert_start_n_i,
                  spi_sdi_i, spi_cs_n_i, spi_sclk_i};

   for (genvar i = 0; i < bmcc_pkg::N_SY; i++) begin : g_edge
      assign chg[i]  = (q.sy[i][1] == q.sy[i][2]) && (q.sy[i][2] != q.lvl[i]);
      assign rise[i] = chg[i] && q.sy[i][2];
      assign fall[i] = chg[i] && !q.sy[i][2];
   end

   assign start_req = fall[bmcc_pkg::SY_CNV] ||
                      (rise[bmcc_pkg::SY_CS] && cs_conv_en_i);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d           = q;
      d.wr_en     = 1'b0;
      d.adc_start = 1'b0;
      d.rx_valid  = 1'b0;
      for (int i = 0; i < bmcc_pkg::N_SY; i++) begin
         d.sy[i] = {q.sy[i][1:0], pins[i]};
         if (q.sy[i][1] == q.sy[i][2]) begin
            d.lvl[i] = q.sy[i][2];
         end
      end
      d.cb    = cb_en_i;
      d.alert = (|q.alert_vec) || q.lvl[bmcc_pkg::SY_ALH];

      // Serial frame: word loaded at select, shifted on rising clock
      if (fall[bmcc_pkg::SY_CS]) begin
         d.sh_out = {q.rd_ptr, rdata, {bmcc_pkg::FR_PAD_W{1'b0}}};
         d.bitcnt = 6'h00;
      end else if (!q.lvl[bmcc_pkg::SY_CS]) begin
         if (rise[bmcc_pkg::SY_SCLK] && q.bitcnt != 6'h00) begin
            d.sh_out = {q.sh_out[30:0], 1'b0};
         end
         if (fall[bmcc_pkg::SY_SCLK] && q.bitcnt < 6'h20) begin
            d.sh_in  = {q.sh_in[30:0], q.lvl[bmcc_pkg::SY_SDI]};
            d.bitcnt = q.bitcnt + 6'h01;
            if (q.bitcnt == 6'h1F) begin
               d.rx_word  = {q.sh_in[30:0], q.lvl[bmcc_pkg::SY_SDI]};
               d.rx_valid = 1'b1;
               d.rd_ptr   = (q.rd_ptr == 4'hB) ? 4'h0 : q.rd_ptr + 4'h1;
            end
         end
      end
      d.sdo = chain_pass_i ? q.lvl[bmcc_pkg::SY_SDH] : d.sh_out[31];

      // Sequencer
      case (q.st)
         bmcc_pkg::BMCC_IDLE: begin
            if (start_req) begin
               d.st     = bmcc_pkg::BMCC_ACQ;
               d.chan   = 4'h0;
               d.rep    = 3'h0;
               d.cnt    = 10'h000;
               d.got    = 1'b0;
               d.acc    = '0;
               d.avg    = avg_sel_i;
               d.acq    = acq_sel_i;
               d.rd_ptr = 4'h0;
            end
         end
         bmcc_pkg::BMCC_ACQ: begin
            d.cnt = q.cnt + 10'h001;
            if (q.cnt == acq_len(q.acq)) begin
               d.adc_start = 1'b1;
               d.st        = bmcc_pkg::BMCC_CONV;
            end
         end
         bmcc_pkg::BMCC_CONV: begin
            if (q.cnt != 10'h3FF) begin
               d.cnt = q.cnt + 10'h001;
            end
            if (adc_rsp_i.done && !q.got) begin
               d.got = 1'b1;
               d.acc = q.acc + bmcc_pkg::ACC_W'(adc_rsp_i.data);
            end
            if (q.got && q.cnt >= slot_len(q.acq)) begin
               if (q.rep == 3'((4'h1 << q.avg) - 4'h1)) begin
                  d.st = bmcc_pkg::BMCC_STORE;
               end else begin
                  d.rep = q.rep + 3'h1;
                  d.cnt = 10'h000;
                  d.got = 1'b0;
                  d.st  = bmcc_pkg::BMCC_ACQ;
               end
            end
         end
         bmcc_pkg::BMCC_STORE: begin
            d.wr_en   = 1'b1;
            d.wr_addr = q.chan;
            d.wr_data = bmcc_pkg::RES_W'(q.acc >> q.avg);
            d.alert_vec[q.chan] = out_of_range(q.chan,
                                               bmcc_pkg::RES_W'(q.acc >> q.avg),
                                               thr_i);
            d.acc = '0;
            d.rep = 3'h0;
            d.cnt = 10'h000;
            d.got = 1'b0;
            if (q.chan == 4'(bmcc_pkg::N_CHAN - 1)) begin
               d.st = bmcc_pkg::BMCC_IDLE;
            end else begin
               d.chan = q.chan + 4'h1;
               d.st   = bmcc_pkg::BMCC_ACQ;
            end
         end
         default: begin
            d.st = bmcc_pkg::BMCC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < bmcc_pkg::N_SY; i++) begin
            q.sy[i] <= {3{bmcc_pkg::SY_RST[i]}};
         end
         q.lvl       <= bmcc_pkg::SY_RST;
         q.st        <= bmcc_pkg::BMCC_IDLE;
         q.chan      <= 4'h0;
         q.rep       <= 3'h0;
         q.cnt       <= 10'h000;
         q.got       <= 1'b0;
         q.acc       <= '0;
         q.avg       <= bmcc_pkg::AVG_RST;
         q.acq       <= bmcc_pkg::ACQ_RST;
         q.adc_start <= 1'b0;
         q.wr_en     <= 1'b0;
         q.wr_addr   <= 4'h0;
         q.wr_data   <= '0;
         q.alert_vec <= '0;
         q.alert     <= 1'b0;
         q.cb        <= 6'h00;
         q.sh_out    <= '0;
         q.sh_in     <= '0;
         q.bitcnt    <= 6'h00;
         q.rd_ptr    <= 4'h0;
         q.sdo       <= 1'b0;
         q.rx_word   <= '0;
         q.rx_valid  <= 1'b0;
      end else begin
         q <= d;
      end
   end

   bmcc_result_mem #(
      .DEPTH (bmcc_pkg::N_CHAN),
      .W     (bmcc_pkg::RES_W)
   ) u_mem (
      .ref_clk_i (ref_clk_i),
      .arst_n_i  (arst_n_i),
      .we_i      (q.wr_en),
      .waddr_i   (q.wr_addr),
      .wdata_i   (q.wr_data),
      .raddr_i   (q.rd_ptr),
      .rdata_q_o (rdata)
   );

   // ----------------------------------------------------------------
   // Outputs; control relayed up the chain
   // ----------------------------------------------------------------
   assign convert_start_relay_up_o = q.lvl[bmcc_pkg::SY_CNV];
   assign sclk_hi_o          = q.lvl[bmcc_pkg::SY_SCLK];
   assign cs_hi_n_o          = q.lvl[bmcc_pkg::SY_CS];
   assign sdo_hi_o           = q.lvl[bmcc_pkg::SY_SDI];
   assign spi_sdo_o          = q.sdo;
   assign sdo_lo_o           = q.sdo;
   assign alert_o            = q.alert;
   assign alert_lo_o         = q.alert;
   assign cell_balance_out_o = q.cb;
   assign adc_req_o.sel      = q.chan;
   assign adc_req_o.start    = q.adc_start;
   assign busy_o             = (q.st != bmcc_pkg::BMCC_IDLE);
   assign rx_word_o          = q.rx_word;
   assign rx_valid_o         = q.rx_valid;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_cnv_start;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      (q.st == bmcc_pkg::BMCC_IDLE && fall[bmcc_pkg::SY_CNV])
      |=> (q.st == bmcc_pkg::BMCC_ACQ && q.chan == 4'h0);
   endproperty
   a_cnv_start: assert property (p_cnv_start)
      else $error("convert start falling edge did not launch at top cell");

   property p_cs_start;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      (q.st == bmcc_pkg::BMCC_IDLE && rise[bmcc_pkg::SY_CS] && cs_conv_en_i)
      |=> busy_o;
   endproperty
   a_cs_start: assert property (p_cs_start)
      else $error("chip select rising edge did not start the sequence");

   property p_busy_ignore;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      (q.st == bmcc_pkg::BMCC_ACQ && q.cnt > 10'h001 && start_req)
      |=> (q.cnt == $past(q.cnt) + 10'h001 && q.chan == $past(q.chan));
   endproperty
   a_busy_ignore: assert property (p_busy_ignore)
      else $error("start request disturbed a running sequence");

   property p_slot_min;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      (q.st == bmcc_pkg::BMCC_CONV && d.st != bmcc_pkg::BMCC_CONV)
      |-> q.cnt >= 10'(bmcc_pkg::CHAN_CYC);
   endproperty
   a_slot_min: assert property (p_slot_min)
      else $error("channel slot shorter than one microsecond");

   property p_acq_time;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      $rose(q.adc_start) |-> $past(q.cnt) == acq_len(q.acq);
   endproperty
   a_acq_time: assert property (p_acq_time)
      else $error("conversion started at wrong acquisition count");

   property p_avg_count;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      q.wr_en |-> $past(q.rep) == 3'((4'h1 << q.avg) - 4'h1);
   endproperty
   a_avg_count: assert property (p_avg_count)
      else $error("stored after wrong number of samples");

   property p_avg_value;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      q.wr_en |-> q.wr_data == bmcc_pkg::RES_W'($past(q.acc) >> $past(q.avg));
   endproperty
   a_avg_value: assert property (p_avg_value)
      else $error("stored value is not the average");

   property p_seq_end;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      $fell(busy_o) |-> (q.wr_en && q.wr_addr == 4'hB);
   endproperty
   a_seq_end: assert property (p_seq_end)
      else $error("sequence ended before the last channel");

   property p_alert_or;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      ##1 alert_o == ($past(|q.alert_vec) || $past(q.lvl[bmcc_pkg::SY_ALH]));
   endproperty
   a_alert_or: assert property (p_alert_or)
      else $error("alert is not local alert ORed with relayed alert");

   property p_frame_len;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      rx_valid_o |-> ($past(q.bitcnt) == 6'h1F && q.bitcnt == 6'h20);
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("word completed after other than 32 clocks");

   property p_balance;
      @(posedge ref_clk_i) disable iff (!arst_n_i)
      ##1 cell_balance_out_o == $past(cb_en_i);
   endproperty
   a_balance: assert property (p_balance)
      else $error("cell balance output does not follow its enable");

endmodule
`default_nettype wire

/* File: rtl/bmcc_pkg.sv */
// Shared constants and types of the battery monitor conversion control
package bmcc_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PS          = 5000;
   localparam int T_CHAN_NS       = 1000;
   localparam int CHAN_CYC        = (T_CHAN_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int T_ACQ_BASE_NS   = 400;
   localparam int ACQ_BASE_CYC    = (T_ACQ_BASE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int T_ACQ_STEP_NS   = 400;
   localparam int ACQ_STEP_CYC    = (T_ACQ_STEP_NS * 1000 + CLK_PS - 1) / CLK_PS;

   // -----------------------------------------------------------------
   // Channels, widths and frame layout
   // -----------------------------------------------------------------
   localparam int N_CELL          = 6;
   localparam int N_AUX           = 6;
   localparam int N_CHAN          = N_CELL + N_AUX;
   localparam int RES_W           = 12;
   localparam int ACC_W           = RES_W + 3;
   localparam int FRAME_BITS      = 32;
   localparam int FR_PAD_W        = FRAME_BITS - 4 - RES_W;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [1:0] AVG_RST = 2'h0;
   localparam logic [1:0] ACQ_RST = 2'h0;

   // -----------------------------------------------------------------
   // Synchroniser slots; chip select and convert start idle high
   // -----------------------------------------------------------------
   localparam int SY_SCLK         = 0;
   localparam int SY_CS           = 1;
   localparam int SY_SDI          = 2;
   localparam int SY_CNV          = 3;
   localparam int SY_ALH          = 4;
   localparam int SY_SDH          = 5;
   localparam int N_SY            = 6;
   localparam logic [5:0] SY_RST  = 6'h0A;

   typedef enum logic [1:0] {
      BMCC_IDLE  = 2'b00,
      BMCC_ACQ   = 2'b01,
      BMCC_CONV  = 2'b10,
      BMCC_STORE = 2'b11
   } bmcc_state_e;

   typedef struct packed {
      logic [1:0]       mode;
      logic [RES_W-1:0] cell_hi;
      logic [RES_W-1:0] cell_lo;
      logic [RES_W-1:0] aux_hi;
      logic [RES_W-1:0] aux_lo;
   } bmcc_thr_s;

   typedef struct packed {
      logic [3:0]       sel;
      logic             start;
   } bmcc_adc_req_s;

   typedef struct packed {
      logic             done;
      logic [RES_W-1:0] data;
   } bmcc_adc_rsp_s;

endpackage

/* File: rtl/bmcc_result_mem.sv */
// Result store: one word per channel, registered read data
`timescale 1ns/100ps
`default_nettype none
module bmcc_result_mem #(
   parameter int DEPTH = 12,
   parameter int W     = 12
) (
   input  wire logic                     ref_clk_i,
   input  wire logic                     arst_n_i,
   input  wire logic                     we_i,
   input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
   input  wire logic [W-1:0]             wdata_i,
   input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
   output logic      [W-1:0]             rdata_q_o
);

   logic [W-1:0] mem_q [DEPTH];

   if (DEPTH < 2 || W < 1) begin : g_chk
      $error("result store depth or width not served");
   end

   always_ff @(posedge ref_clk_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_q_o <= '0;
      end else begin
         rdata_q_o <= mem_q[raddr_i];
      end
   end

endmodule
`default_nettype wire

/* File: verification/battery_monitor_conversion_control_test.sv */
// Self-checking bench of the conversion control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin fail_count++; \
   $display("wrong value at %0t: %s", $time, m); end end
module battery_monitor_conversion_control_test;
   logic                    ref_clk_i = 1'b0;
   logic                    arst_n_i = 1'b0;
   logic                    cnv_n = 1'b1;
   logic                    alert_hi = 1'b0;
   logic                    sdi_hi = 1'b0;
   logic                    pass = 1'b0;
   logic                    cs_en = 1'b0;
   logic                    go = 1'b0;
   logic [1:0]              avg = 2'h0;
   logic [1:0]              acq = 2'h0;
   logic [5:0]              cb = 6'h00;
   logic [3:0]              base = 4'h0;
   logic [31:0]             tx = 32'h0;
   bmcc_pkg::bmcc_thr_s     thr = '0;
   bmcc_pkg::bmcc_adc_rsp_s rsp = '0;
   bmcc_pkg::bmcc_adc_req_s req;
   logic                    sclk, cs_n, sdi, sdo, done, sclk_hi, cs_hi_n, sdo_hi, sdo_lo;
   logic                    relay, alert, alert_lo, busy, rxv;
   logic [31:0]             rx, rxw;
   logic [5:0]              cb_out;
   int                      fail_count = 0, compares = 0, n_start = 0;
   int                      gap = 0, dly = 0, ns = 1, slot = bmcc_pkg::CHAN_CYC, n_rxv = 0;

   always #2.5 ref_clk_i = ~ref_clk_i;

   bmcc_conv_ctrl dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
      .convert_start_n_i(cnv_n), .convert_start_relay_up_o(relay),
      .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
      .sclk_hi_o(sclk_hi), .cs_hi_n_o(cs_hi_n), .sdo_hi_o(sdo_hi), .sdi_hi_i(sdi_hi),
      .sdo_lo_o(sdo_lo), .alert_hi_i(alert_hi), .alert_o(alert), .alert_lo_o(alert_lo),
      .chain_pass_i(pass), .cs_conv_en_i(cs_en), .avg_sel_i(avg), .acq_sel_i(acq),
      .thr_i(thr), .cb_en_i(cb), .cell_balance_out_o(cb_out), .adc_req_o(req),
      .adc_rsp_i(rsp), .busy_o(busy), .rx_word_o(rxw), .rx_valid_o(rxv));

   bmcc_spi_host_model host_u (.go_i(go), .tx_i(tx), .sdo_i(sdo), .sclk_o(sclk),
      .cs_n_o(cs_n), .sdi_o(sdi), .rx_q_o(rx), .done_o(done));

   function automatic logic [11:0] val(input logic [3:0] ch, input int k);
      return 12'({ch, 8'h00}) + 12'(k * 3) + 12'(base);
   endfunction

   function automatic logic [11:0] expv(input int ch);
      logic [14:0] s;
      s = '0;
      for (int k = 0; k < (1 << avg); k++) s += 15'(val(4'(ch), k));
      return 12'(s >> avg);
   endfunction

   function automatic logic exp_alert();
      logic [11:0] e;
      exp_alert = 1'b0;
      for (int c = 0; c < 12; c++) begin
         e = expv(c);
         if (c < 6 && thr.mode[0] && (e > thr.cell_hi || e < thr.cell_lo)) exp_alert = 1'b1;
         if (c >= 6 && thr.mode[1] && (e > thr.aux_hi || e < thr.aux_lo)) exp_alert = 1'b1;
      end
   endfunction

   // Converter model: answers each start after a channel-dependent delay
   always @(posedge ref_clk_i) begin
      rsp.done <= (dly == 1);
      gap <= (req.start === 1'b1) ? 1 : gap + 1;
      if (req.start === 1'b1) begin
         `CHK(req.sel, 4'(n_start / ns), "channel order")
         if (n_start > 0) `CHK(gap >= slot, 1'b1, "slot short")
         rsp.data <= val(req.sel, n_start % ns);
         n_start <= n_start + 1;
         dly <= 4 + int'(req.sel);
      end else if (dly > 0) begin
         dly <= dly - 1;
      end
   end

   // Each completed word gives exactly one valid pulse
   always @(posedge ref_clk_i) if (rxv === 1'b1) n_rxv <= n_rxv + 1;

   task automatic wrap_up();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic wait_busy(input logic v, input int lim);
      for (int i = 0; i < lim && busy !== v; i++) step(1);
      if (busy !== v) begin
         fail_count++;
         wrap_up();
      end
   endtask

   task automatic frame(input logic [31:0] w);
      tx = w;
      go = 1'b1;
      step(1);
      go = 1'b0;
      for (int i = 0; i < 2000 && done !== 1'b1; i++) step(1);
      if (done !== 1'b1) begin
         fail_count++;
         wrap_up();
      end
      step(20);
   endtask

   initial begin
      void'($urandom(85027));
      step(10);
      arst_n_i = 1'b1;
      step(10);
      `CHK(relay, 1'b1, "relay idle")
      `CHK(busy, 1'b0, "busy idle")
      for (int i = 0; i < 8; i++) begin
         cb = 6'($urandom);
         step(1);
         `CHK(cb_out, cb, "balance")
      end
      alert_hi = 1'b1;
      step(8);
      `CHK(alert, 1'b1, "alert relay")
      `CHK(alert_lo, 1'b1, "alert down")
      alert_hi = 1'b0;
      step(8);
      `CHK(alert, 1'b0, "alert clear")
      for (int i = 0; i < 4; i++) begin
         pass = 1'b1;
         sdi_hi = i[0];
         step(10);
         `CHK(sdo, sdi_hi, "pass down")
         `CHK(sdo_lo, sdo, "sdo copy")
      end
      pass = 1'b0;
      frame(32'($urandom));
      `CHK(rxw, tx, "rx word")
      `CHK(n_rxv, 1, "rx valid pulse")
      `CHK(sdo_hi, sdi, "sdi up")
      `CHK(cs_hi_n, cs_n, "cs up")
      `CHK(sclk_hi, sclk, "sclk up")
      // Pin start with averaging; a second start while busy is ignored
      base = 4'($urandom);
      avg = 2'($urandom);
      ns = 1 << avg;
      thr = '{2'h1, 12'h400, 12'h010, 12'hFFF, 12'h000};
      n_start = 0;
      cnv_n = 1'b0;
      step(8);
      `CHK(relay, 1'b0, "relay low")
      cnv_n = 1'b1;
      wait_busy(1'b1, 20);
      step(230);
      cnv_n = 1'b0;
      step(8);
      cnv_n = 1'b1;
      wait_busy(1'b0, 30000);
      step(10);
      `CHK(n_start, 12 * ns, "start count")
      `CHK(alert, exp_alert(), "alert set")
      for (int i = 0; i < 12; i++) begin
         frame(32'($urandom));
         `CHK(rx, {4'(i), expv(i), 16'h0000}, "result")
      end
      `CHK(n_rxv, 13, "rx valid count")
      // Chip-select start with long acquisition, aux checks only
      cs_en = 1'b1;
      acq = 2'h3;
      avg = 2'h0;
      ns = 1;
      slot = bmcc_pkg::CHAN_CYC + 3 * bmcc_pkg::ACQ_STEP_CYC;
      thr.mode = 2'h2;
      n_start = 0;
      frame(32'($urandom));
      wait_busy(1'b1, 20);
      cs_en = 1'b0;
      wait_busy(1'b0, 20000);
      step(10);
      `CHK(n_start, 12, "cs start count")
      `CHK(alert, 1'b0, "alert renewed")
      // Pin start with random acquisition; only an auxiliary channel trips
      acq = 2'($urandom);
      slot = bmcc_pkg::CHAN_CYC + int'(acq) * bmcc_pkg::ACQ_STEP_CYC;
      thr.aux_lo = 12'h700;
      n_start = 0;
      cnv_n = 1'b0;
      step(8);
      cnv_n = 1'b1;
      wait_busy(1'b1, 20);
      wait_busy(1'b0, 20000);
      step(10);
      `CHK(n_start, 12, "aux start count")
      `CHK(alert, exp_alert(), "aux alert")
      wrap_up();
   end
endmodule
`default_nettype wire

/* File: verification/bmcc_spi_host_model.sv */
// Behavioural serial controller: one 32-bit frame per request
`timescale 1ns/100ps
`default_nettype none
module bmcc_spi_host_model (
   input  wire logic        go_i,
   input  wire logic [31:0] tx_i,
   input  wire logic        sdo_i,
   output logic             sclk_o,
   output logic             cs_n_o,
   output logic             sdi_o,
   output logic [31:0]      rx_q_o,
   output logic             done_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b1;
      rx_q_o = 32'h0;
      done_o = 1'b0;
   end
   // Clock rests low between frames; released data shows the inverse bit
   always @(posedge go_i) begin
      done_o = 1'b0;
      cs_n_o = 1'b0;
      #200;
      for (int i = 31; i >= 0; i--) begin
         #40 sclk_o = 1'b1;
         sdi_o = tx_i[i];
         #40 sclk_o = 1'b0;
         rx_q_o[i] = sdo_i;
      end
      #100 cs_n_o = 1'b1;
      sdi_o = ~tx_i[0];
      done_o = 1'b1;
   end
endmodule
`default_nettype wire
